// ---- design/scr_map.svh ----
/*
 * Offsets, reset values and widths of the system control and scratch
 * register group. Assumes a 32-bit register bus with byte addresses.
 */
`ifndef SCR_MAP_SVH
`define SCR_MAP_SVH

`define SCR_OFF_OVR        12'h040
`define SCR_OFF_LOCK       12'h044
`define SCR_OFF_STICKY0    12'h100
`define SCR_OFF_STICKY1    12'h104
`define SCR_OFF_STICKY2    12'h108
`define SCR_OFF_STICKY3    12'h10C
`define SCR_OFF_PLAIN0     12'h114
`define SCR_OFF_PLAIN1     12'h118
`define SCR_OFF_PLAIN2     12'h11C
`define SCR_OFF_PLAIN3     12'h120
`define SCR_OFF_SET_ONCE   12'h130
`define SCR_OFF_SET_STICKY 12'h134
`define SCR_OFF_COMPARATOR_IRQ_ENABLE     12'h300
`define SCR_OFF_CMP_REF    12'h304
`define SCR_OFF_IRQ_STAT   12'h340
`define SCR_OFF_IRQ_MASK   12'h344

`define SCR_RST_WORD       32'h0000_0000
`define SCR_RST_BIT        1'b0
`define SCR_CMP_N          19
`define SCR_OVR_BIT        0
`define SCR_LOCK_BIT       0

`endif

// ---- design/scr_pkg.sv ----
/*
 * Types shared by the system control and scratch register group.
 * Assumes nothing beyond the map header.
 */
package scr_pkg;

  typedef enum logic [1:0] {
    SCR_RESP_OKAY   = 2'b00,
    SCR_RESP_SLVERR = 2'b10
  } scr_resp_type;

endpackage

// ---- design/scr_regs.sv ----
/*
 * System control and scratch register group with an AXI4-Lite slave,
 * a debug access gate, comparator configuration and a comparator
 * interrupt with sticky status and mask.
 * Assumes aresetn is the power-on reset, cold and warm reset requests
 * and comparator outputs arrive asynchronously on pins.
 */
// The AXI4-Lite interface to the registers is this design's own decision.
// Function
// [R1] Bit 0 at 0x40 overrides security restrictions; bits 31:1 read zero.
// [R2] Programmed OTP area with override clear denies debug test access.
// [R3] Boot firmware writes the override after cold reset, may lock it.
// [R4] Bit 0 at 0x44 is set-only lock; only power-on reset clears it.
// [R5] Four sticky scratchpads 0x100-0x10C clear on power-on or cold reset.
// [R6] Four scratchpads 0x114-0x120 clear on any reset.
// [R7] Scratchpad 0x130 sets bits written one, keeps them until reset.
// [R8] Sticky set-only scratchpad 0x134 clears only on power-on reset.
// [R9] Bits 18:0 at 0x300 enable each comparator interrupt.
// [R10] Bits 18:0 at 0x304 pick external pin or internal reference.
// [R11] Each bit 0 to 18 serves exactly one of nineteen comparators.
// [R12] Reserved bits ignore writes and read as zero.
// [R13] While locked, writes to the override bit are ignored.
`timescale 1ns/10ps
`include "scr_map.svh"

module scr_regs
  import scr_pkg::*;
#(
  parameter int CMP_N = `SCR_CMP_N
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             cold_rst_req_n,
  input  wire logic             warm_rst_req_n,
  input  wire logic             otp_programmed,
  input  wire logic [CMP_N-1:0] cmp_out,
  input  wire logic [11:0]      s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [11:0]      s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  output logic                  security_override,
  output logic                  security_override_freeze,
  output logic                  debug_access_deny,
  output logic [CMP_N-1:0]      comparator_irq_enable,
  output logic [CMP_N-1:0]      comparator_ref_source,
  output logic                  irq
);

  // ***********************************************************
  // Functions
  // ***********************************************************
  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [31:0] mask);
    merge = (old & ~mask) | (data & mask);
  endfunction

  function automatic logic [31:0] widen(input logic [CMP_N-1:0] v);
    widen = 32'(v);
  endfunction

  // ***********************************************************
  // Reset requests
  // ***********************************************************
  // Both request pins pass two flops; the first is read only by the
  // second. The flops start asserted so a power-on also acts as both.
  logic cold_s1;
  logic cold_s2;
  logic warm_s1;
  logic warm_s2;
  logic otp_s1;
  logic otp_s2;
  logic [CMP_N-1:0] cmp_s1;
  logic [CMP_N-1:0] cmp_s2;
  logic [CMP_N-1:0] cmp_prev;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cold_s1 <= 1'b0;
      cold_s2 <= 1'b0;
      warm_s1 <= 1'b0;
      warm_s2 <= 1'b0;
    end else begin
      cold_s1 <= cold_rst_req_n;
      cold_s2 <= cold_s1;
      warm_s1 <= warm_rst_req_n;
      warm_s2 <= warm_s1;
    end
  end

  always_ff @(posedge aclk) begin
    otp_s1 <= otp_programmed;
    otp_s2 <= otp_s1;
    cmp_s1 <= cmp_out;
    cmp_s2 <= cmp_s1;
  end

  wire por_rst  = !aresetn;
  wire cold_rst = por_rst | !cold_s2;
  wire warm_rst = cold_rst | !warm_s2;

  // ***********************************************************
  // Bus write path
  // ***********************************************************
  // Address and data are held separately so the master may offer them
  // in either order; the write acts once both are held.
  logic        aw_held;
  logic        w_held;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  wire do_wr   = aw_held & w_held & !s_axi_bvalid;
  wire [31:0] wmask = strb_mask(wr_strb);

  wire wr_ovr   = do_wr & (wr_addr == `SCR_OFF_OVR);
  wire wr_lock  = do_wr & (wr_addr == `SCR_OFF_LOCK);
  wire wr_st0   = do_wr & (wr_addr == `SCR_OFF_STICKY0);
  wire wr_st1   = do_wr & (wr_addr == `SCR_OFF_STICKY1);
  wire wr_st2   = do_wr & (wr_addr == `SCR_OFF_STICKY2);
  wire wr_st3   = do_wr & (wr_addr == `SCR_OFF_STICKY3);
  wire wr_pl0   = do_wr & (wr_addr == `SCR_OFF_PLAIN0);
  wire wr_pl1   = do_wr & (wr_addr == `SCR_OFF_PLAIN1);
  wire wr_pl2   = do_wr & (wr_addr == `SCR_OFF_PLAIN2);
  wire wr_pl3   = do_wr & (wr_addr == `SCR_OFF_PLAIN3);
  wire wr_so    = do_wr & (wr_addr == `SCR_OFF_SET_ONCE);
  wire wr_ss    = do_wr & (wr_addr == `SCR_OFF_SET_STICKY);
  wire wr_cen   = do_wr & (wr_addr == `SCR_OFF_COMPARATOR_IRQ_ENABLE);
  wire wr_cref  = do_wr & (wr_addr == `SCR_OFF_CMP_REF);
  wire wr_stat  = do_wr & (wr_addr == `SCR_OFF_IRQ_STAT);
  wire wr_mask  = do_wr & (wr_addr == `SCR_OFF_IRQ_MASK);
  wire wr_hit   = wr_ovr | wr_lock | wr_st0 | wr_st1 | wr_st2 | wr_st3 |
                  wr_pl0 | wr_pl1 | wr_pl2 | wr_pl3 | wr_so | wr_ss |
                  wr_cen | wr_cref | wr_stat | wr_mask;

  wire next_aw_held = aw_take | (aw_held & !do_wr);
  wire next_w_held  = w_take | (w_held & !do_wr);
  wire next_bvalid  = do_wr | (s_axi_bvalid & !s_axi_bready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      wr_addr <= 12'h000;
      wr_data <= `SCR_RST_WORD;
      wr_strb <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_held <= 1'b1;
        wr_addr <= {s_axi_awaddr[11:2], 2'b00};
      end else if (do_wr) begin
        aw_held <= 1'b0;
      end
      if (w_take) begin
        w_held  <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end else if (do_wr) begin
        w_held <= 1'b0;
      end
    end
  end

  // Each ready is loaded with what the hold flags will be after the
  // edge, so it falls in the cycle that a take or a response begins
  // while still leaving the pin on a flop.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= SCR_RESP_OKAY;
    end else begin
      s_axi_awready <= !next_aw_held & !next_bvalid;
      s_axi_wready  <= !next_w_held & !next_bvalid;
      s_axi_bvalid  <= next_bvalid;
      if (do_wr) begin
        s_axi_bresp <= wr_hit ? SCR_RESP_OKAY : SCR_RESP_SLVERR;
      end
    end
  end

  // ***********************************************************
  // Security override and its freeze
  // ***********************************************************
  // The override survives a warm reset so boot firmware sets it once
  // per cold start; the freeze answers to power-on reset alone.
  always_ff @(posedge aclk) begin
    if (por_rst) begin
      security_override_freeze <= `SCR_RST_BIT; // [R4]
    end else if (wr_lock & wmask[`SCR_LOCK_BIT]) begin
      security_override_freeze <= security_override_freeze |
                                  wr_data[`SCR_LOCK_BIT]; // [R4]
    end
  end

  always_ff @(posedge aclk) begin
    if (cold_rst) begin
      security_override <= `SCR_RST_BIT;
    end else if (wr_ovr & wmask[`SCR_OVR_BIT] &
                 !security_override_freeze) begin // [R13]
      security_override <= wr_data[`SCR_OVR_BIT]; // [R1]
    end
  end

  always_ff @(posedge aclk) begin
    if (por_rst) begin
      debug_access_deny <= 1'b1;
    end else begin
      debug_access_deny <= otp_s2 & !security_override; // [R2]
    end
  end

  // ***********************************************************
  // Scratchpads
  // ***********************************************************
  logic [31:0] sticky_scratch [4];
  logic [31:0] plain_scratch [4];
  logic [31:0] set_once_scratch;
  logic [31:0] set_once_sticky_scratch;

  wire [3:0] wr_st = {wr_st3, wr_st2, wr_st1, wr_st0};
  wire [3:0] wr_pl = {wr_pl3, wr_pl2, wr_pl1, wr_pl0};

  always_ff @(posedge aclk) begin
    for (int i = 0; i < 4; i++) begin
      if (cold_rst) begin
        sticky_scratch[i] <= `SCR_RST_WORD; // [R5]
      end else if (wr_st[i]) begin
        sticky_scratch[i] <= merge(sticky_scratch[i], wr_data, wmask);
      end
      if (warm_rst) begin
        plain_scratch[i] <= `SCR_RST_WORD; // [R6]
      end else if (wr_pl[i]) begin
        plain_scratch[i] <= merge(plain_scratch[i], wr_data, wmask);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (warm_rst) begin
      set_once_scratch <= `SCR_RST_WORD;
    end else if (wr_so) begin
      set_once_scratch <= set_once_scratch | (wr_data & wmask); // [R7]
    end
  end

  always_ff @(posedge aclk) begin
    if (por_rst) begin
      set_once_sticky_scratch <= `SCR_RST_WORD; // [R8]
    end else if (wr_ss) begin
      set_once_sticky_scratch <= set_once_sticky_scratch |
                                 (wr_data & wmask); // [R8]
    end
  end

  // ***********************************************************
  // Comparator configuration and interrupt
  // ***********************************************************
  // Only the low CMP_N bits are stored, so upper bits of any write are
  // dropped and read back as zero.
  logic [CMP_N-1:0] irq_status;
  logic [CMP_N-1:0] irq_mask;

  wire [CMP_N-1:0] wdat_n  = wr_data[CMP_N-1:0]; // [R12]
  wire [CMP_N-1:0] wmask_n = wmask[CMP_N-1:0];
  wire [CMP_N-1:0] cmp_rise = cmp_s2 & ~cmp_prev;
  wire [CMP_N-1:0] cmp_event = cmp_rise & comparator_irq_enable; // [R9]
  wire [CMP_N-1:0] stat_clr = wr_stat ? (wdat_n & wmask_n) : '0;

  always_ff @(posedge aclk) begin
    if (cold_rst) begin
      comparator_irq_enable <= '0;
      comparator_ref_source <= '0;
      irq_mask              <= '0;
    end else begin
      if (wr_cen) begin
        comparator_irq_enable <= (comparator_irq_enable & ~wmask_n) |
                                 (wdat_n & wmask_n); // [R11]
      end
      if (wr_cref) begin
        comparator_ref_source <= (comparator_ref_source & ~wmask_n) |
                                 (wdat_n & wmask_n); // [R10]
      end
      if (wr_mask) begin
        irq_mask <= (irq_mask & ~wmask_n) | (wdat_n & wmask_n);
      end
    end
  end

  // A new edge in the same cycle as a clear keeps its bit set.
  always_ff @(posedge aclk) begin
    if (cold_rst) begin
      irq_status <= '0;
      cmp_prev   <= '0;
      irq        <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~stat_clr) | cmp_event;
      cmp_prev   <= cmp_s2;
      irq        <= |(irq_status & irq_mask);
    end
  end

  // ***********************************************************
  // Bus read path
  // ***********************************************************
  wire [11:0] ra = {s_axi_araddr[11:2], 2'b00};
  wire ar_take = s_axi_arvalid & s_axi_arready;

  wire rd_ovr  = ra == `SCR_OFF_OVR;
  wire rd_lock = ra == `SCR_OFF_LOCK;
  wire rd_st   = (ra >= `SCR_OFF_STICKY0) & (ra <= `SCR_OFF_STICKY3);
  wire rd_pl   = (ra >= `SCR_OFF_PLAIN0) & (ra <= `SCR_OFF_PLAIN3);
  wire rd_so   = ra == `SCR_OFF_SET_ONCE;
  wire rd_ss   = ra == `SCR_OFF_SET_STICKY;
  wire rd_cen  = ra == `SCR_OFF_COMPARATOR_IRQ_ENABLE;
  wire rd_cref = ra == `SCR_OFF_CMP_REF;
  wire rd_stat = ra == `SCR_OFF_IRQ_STAT;
  wire rd_mask = ra == `SCR_OFF_IRQ_MASK;
  wire rd_hit  = rd_ovr | rd_lock | rd_st | rd_pl | rd_so | rd_ss |
                 rd_cen | rd_cref | rd_stat | rd_mask;

  wire [11:0] pl_off = ra - `SCR_OFF_PLAIN0;
  wire [1:0]  st_idx = ra[3:2];
  wire [1:0]  pl_idx = pl_off[3:2];

  wire [31:0] rd_word =
    rd_ovr  ? {31'h0000_0000, security_override} : // [R1]
    rd_lock ? {31'h0000_0000, security_override_freeze} :
    rd_st   ? sticky_scratch[st_idx] :
    rd_pl   ? plain_scratch[pl_idx] :
    rd_so   ? set_once_scratch :
    rd_ss   ? set_once_sticky_scratch :
    rd_cen  ? widen(comparator_irq_enable) : // [R12]
    rd_cref ? widen(comparator_ref_source) :
    rd_stat ? widen(irq_status) :
    rd_mask ? widen(irq_mask) : `SCR_RST_WORD;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= `SCR_RST_WORD;
      s_axi_rresp  <= SCR_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? SCR_RESP_OKAY : SCR_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // The address channel stays refused from the take until the edge
  // that ends the answer, so only one read is ever in flight.
  wire next_rvalid = ar_take | (s_axi_rvalid & !s_axi_rready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !next_rvalid;
    end
  end

endmodule

// ---- bench/scr_regs_monitor.sv ----
/*
 * Port checker for scr_regs: bus answers, override lock, debug gate.
 * Assumes a bind onto scr_regs, one clock aclk, aresetn power-on reset.
 */
`timescale 1ns/10ps

module scr_regs_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        cold_rst_req_n,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        security_override,
  input wire logic        security_override_freeze,
  input wire logic        debug_access_deny
);
  // ****************************************************************
  // Helper logic and properties
  // ****************************************************************
  // Cold reset acts through a synchroniser, so the lock check waits
  // until the request pin has been quiet for four edges.
  logic [3:0]  cold_hist;
  logic [11:0] rd_addr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cold_hist <= 4'h0;
    end else begin
      cold_hist <= {cold_hist[2:0], cold_rst_req_n};
    end
  end

  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      rd_addr <= s_axi_araddr;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence

  property p_freeze_keep;
    security_override_freeze |=> security_override_freeze;
  endproperty
  property p_ovr_frozen;
    security_override_freeze && cold_rst_req_n && (&cold_hist)
      |=> $stable(security_override);
  endproperty
  property p_deny_ovr;
    $past(security_override) |-> !debug_access_deny;
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_ar_answer;
    s_ar_take |=> s_axi_rvalid;
  endproperty
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  property p_w_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_ctrl_rsvd;
    s_axi_rvalid && rd_addr[11:3] == 9'h008 |-> s_axi_rdata[31:1] == 31'h0;
  endproperty

  a_freeze_keep: assert property (p_freeze_keep)
    else $error("lock bit dropped");
  a_ovr_frozen: assert property (p_ovr_frozen)
    else $error("override changed while locked");
  a_deny_ovr: assert property (p_deny_ovr)
    else $error("debug denied under override");
  a_b_hold: assert property (p_b_hold)
    else $error("write response withdrawn");
  a_r_hold: assert property (p_r_hold)
    else $error("read response withdrawn or changed");
  a_ar_answer: assert property (p_ar_answer)
    else $error("read answer late");
  a_ar_block: assert property (p_ar_block)
    else $error("read address taken while busy");
  a_w_block: assert property (p_w_block)
    else $error("write taken while response pending");
  a_ctrl_rsvd: assert property (p_ctrl_rsvd)
    else $error("reserved control bits nonzero");
endmodule

bind scr_regs scr_regs_monitor i_mon (
  .aclk(aclk), .aresetn(aresetn), .cold_rst_req_n(cold_rst_req_n),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .security_override(security_override),
  .security_override_freeze(security_override_freeze),
  .debug_access_deny(debug_access_deny)
);

// ---- bench/system_control_scratch_regs_tb.sv ----
/*
 * Self-checking bench for scr_regs over AXI4-Lite.
 * Assumes the map header and package; ready is raised late on purpose.
 */
`timescale 1ns/10ps
`include "scr_map.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

module system_control_scratch_regs_tb
  import scr_pkg::*;
;
  // ****************************************************************
  // Signals, tasks and sequence
  // ****************************************************************
  logic        aclk, aresetn, cold_rst_req_n, warm_rst_req_n;
  logic        otp_programmed, irq;
  logic [18:0] cmp_out, comparator_irq_enable, comparator_ref_source;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        security_override, security_override_freeze;
  logic        debug_access_deny;
  int          miscompares, checks, cycles;
  logic [11:0] offs [14] = '{`SCR_OFF_OVR, `SCR_OFF_LOCK, `SCR_OFF_STICKY0,
    `SCR_OFF_STICKY1, `SCR_OFF_STICKY2, `SCR_OFF_STICKY3, `SCR_OFF_PLAIN0,
    `SCR_OFF_PLAIN1, `SCR_OFF_PLAIN2, `SCR_OFF_PLAIN3, `SCR_OFF_SET_ONCE,
    `SCR_OFF_SET_STICKY, `SCR_OFF_COMPARATOR_IRQ_ENABLE, `SCR_OFF_CMP_REF};

  scr_regs i_dut (.aclk, .aresetn, .cold_rst_req_n, .warm_rst_req_n,
    .otp_programmed, .cmp_out, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .security_override,
    .security_override_freeze, .debug_access_deny, .comparator_irq_enable,
    .comparator_ref_source, .irq);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      wrap_up();
    end
  end

  function automatic logic [31:0] pat(input int i);
    return {24'hA5C3F0, 8'(i + 1)};
  endfunction

  function automatic logic [31:0] msk(input int i);
    return i < 2 ? 32'h1 : (i > 11 ? 32'h7FFFF : 32'hFFFFFFFF);
  endfunction

  task automatic tick(input int k);
    repeat (k) @(posedge aclk);
  endtask

  // Handshakes are judged at the falling edge, where all is settled.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    int n;
    hb = 1'b0;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    while (!hb) begin
      @(negedge aclk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid && s_axi_bready;
      rsp = s_axi_bresp;
      @(posedge aclk);
      n++;
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      s_axi_bready <= n >= 3 && !hb;
    end
  endtask

  task automatic rd(input logic [11:0] a);
    logic ha, hr;
    int n;
    hr = 1'b0;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!hr) begin
      @(negedge aclk);
      ha = s_axi_arvalid && s_axi_arready;
      hr = s_axi_rvalid && s_axi_rready;
      rdat = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
      n++;
      if (ha) s_axi_arvalid <= 1'b0;
      s_axi_rready <= n >= 2 && !hr;
    end
  endtask

  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    `CHK(rdat, e);
  endtask

  task automatic wrap_up();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    {miscompares, checks, cycles} = '0;
    {aresetn, cmp_out, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} <= '0;
    {s_axi_wdata, s_axi_wstrb} <= '0;
    {cold_rst_req_n, warm_rst_req_n, otp_programmed} <= 3'h7;
    tick(4);
    aresetn <= 1'b1;
    tick(3);
    foreach (offs[i]) rc(offs[i], 32'h0);
    `CHK(debug_access_deny, 1'b1);
    `CHK(security_override, 1'b0);
    `CHK(security_override_freeze, 1'b0);
    foreach (offs[i]) wr(offs[i], pat(i));
    `CHK(rsp, SCR_RESP_OKAY);
    foreach (offs[i]) rc(offs[i], pat(i) & msk(i));
    `CHK(comparator_irq_enable, 19'(pat(12)));
    `CHK(comparator_ref_source, 19'(pat(13)));
    `CHK(debug_access_deny, 1'b0);
    `CHK(security_override, 1'b1);
    for (int b = 0; b < 19; b++) begin
      wr(`SCR_OFF_CMP_REF, 32'h1 << b);
      `CHK(comparator_ref_source, 19'h1 << b);
    end
    wr(`SCR_OFF_SET_ONCE, 32'h00000F00);
    wr(`SCR_OFF_SET_ONCE, 32'h0);
    rc(`SCR_OFF_SET_ONCE, pat(10) | 32'h00000F00);
    wr(`SCR_OFF_SET_STICKY, 32'hF0000000);
    rc(`SCR_OFF_SET_STICKY, pat(11) | 32'hF0000000);
    wr(12'h200, 32'hFFFFFFFF);
    `CHK(rsp, SCR_RESP_SLVERR);
    rd(12'h200);
    `CHK(rsp, SCR_RESP_SLVERR);
    `CHK(rdat, 32'h0);
    wr(`SCR_OFF_LOCK, 32'h1);
    rc(`SCR_OFF_LOCK, 32'h1);
    `CHK(security_override_freeze, 1'b1);
    wr(`SCR_OFF_OVR, 32'h0);
    rc(`SCR_OFF_OVR, 32'h1);
    // Bits 0, 2 and 3 are enabled, bit 1 is not; only 0 and 2 unmasked.
    wr(`SCR_OFF_IRQ_MASK, 32'h5);
    cmp_out <= 19'h0000F;
    tick(6);
    rc(`SCR_OFF_IRQ_STAT, 32'hD);
    `CHK(irq, 1'b1);
    wr(`SCR_OFF_IRQ_STAT, 32'h5);
    rc(`SCR_OFF_IRQ_STAT, 32'h8);
    `CHK(irq, 1'b0);
    warm_rst_req_n <= 1'b0;
    tick(4);
    warm_rst_req_n <= 1'b1;
    tick(5);
    for (int i = 2; i < 10; i++) rc(offs[i], i < 6 ? pat(i) : 32'h0);
    rc(`SCR_OFF_SET_ONCE, 32'h0);
    rc(`SCR_OFF_OVR, 32'h1);
    cold_rst_req_n <= 1'b0;
    tick(4);
    cold_rst_req_n <= 1'b1;
    tick(5);
    for (int i = 2; i < 10; i++) rc(offs[i], 32'h0);
    rc(`SCR_OFF_SET_STICKY, pat(11) | 32'hF0000000);
    rc(`SCR_OFF_LOCK, 32'h1);
    rc(`SCR_OFF_COMPARATOR_IRQ_ENABLE, 32'h0);
    wr(`SCR_OFF_OVR, 32'h1);
    rc(`SCR_OFF_OVR, 32'h0);
    `CHK(debug_access_deny, 1'b1);
    aresetn <= 1'b0;
    otp_programmed <= 1'b0;
    tick(4);
    aresetn <= 1'b1;
    tick(5);
    rc(`SCR_OFF_LOCK, 32'h0);
    `CHK(security_override_freeze, 1'b0);
    rc(`SCR_OFF_SET_STICKY, 32'h0);
    `CHK(debug_access_deny, 1'b0);
    wr(`SCR_OFF_OVR, 32'h1);
    rc(`SCR_OFF_OVR, 32'h1);
    `CHK(security_override, 1'b1);
    wrap_up();
  end
endmodule
